// ### pkg/pcrb_pkg.sv
// Package: register map, field layout and port bundles of the pull control bank
package pcrb_pkg;

   // Register addresses
   localparam logic [7:0] ADDR_OFFSET_LOW    = 8'h00;
   localparam logic [7:0] ADDR_OFFSET_HIGH   = 8'h01;
   localparam logic [7:0] ADDR_PULL_RANGE    = 8'h02;

   // Field layout
   localparam int REG_W          = 16;
   localparam int LOW_W          = 16;
   localparam int HIGH_W         = 10;
   localparam int OFFSET_W       = 26;
   localparam int OE_BIT         = 10;
   localparam int RANGE_W        = 4;

   // Reset values
   localparam logic [LOW_W-1:0]    LOW_RESET    = 16'h0000;
   localparam logic [HIGH_W-1:0]   HIGH_RESET   = 10'h000;
   localparam logic                OE_RESET     = 1'b0;
   localparam logic [RANGE_W-1:0]  RANGE_RESET  = 4'h0;
   localparam logic [REG_W-1:0]    READ_ZERO    = 16'h0000;

   // Register access request from the serial slave front end
   typedef struct packed {
      logic              wr_en;
      logic              rd_en;
      logic [7:0]        addr;
      logic [REG_W-1:0]  wdata;
   } pcrb_req_t;

   // Read answer back to the serial slave front end
   typedef struct packed {
      logic              valid;
      logic [REG_W-1:0]  data;
   } pcrb_rsp_t;

   // Whole state of the bank
   typedef struct packed {
      logic [LOW_W-1:0]     low_word;
      logic [HIGH_W-1:0]    high_word;
      logic                 oe_bit;
      logic [RANGE_W-1:0]   pull_range;
      logic                 range_loaded;
      logic [OFFSET_W-1:0]  applied;
      logic                 update;
      pcrb_rsp_t            rsp;
   } pcrb_state_t;

endpackage

// ### rtl/pcrb_bank.sv
// Pull control register bank: offset word, output enable and pull range
`timescale 1ns/1ps
//
// Summary of operation
// - Pull range, offset and output enable are set by writes to 0x00-0x02.
// - Register 0x00 holds the low 16 offset bits, read and write.
// - Register 0x01 bits 9..0 hold the upper 10 offset bits, read and write.
// - After power-up the whole 26-bit offset word is zero.
// - The 26-bit offset word is a signed two's complement value.
// - A new offset is applied only when the high word is written.
// - Bit 10 of 0x01 enables the output driver while oe_sw_mode is set and resets to zero.
// - The enable bit is written only under software enable control.
// - Bits 15..11 of 0x01 read as zero and ignore writes.
// - Bits 3..0 of 0x02 select the pull range; bits 15..4 read only.
// - Range codes 0..15 select 6.25 up to 3200 ppm in ascending order.
// - The range field loads a factory value in the first cycle after each reset release, then is writable.

module pcrb_bank (
   input  wire logic                               clk_sys,
   input  wire logic                               reset,
   input  wire pcrb_pkg::pcrb_req_t                req,
   input  wire logic                               oe_sw_mode,
   input  wire logic [pcrb_pkg::RANGE_W-1:0]       factory_range,
   output pcrb_pkg::pcrb_rsp_t                     rsp,
   output logic signed [pcrb_pkg::OFFSET_W-1:0]    pull_offset_word,
   output logic                                    offset_update,
   output logic                                    out_drive_enable,
   output logic [pcrb_pkg::RANGE_W-1:0]            pull_range
);

   ////////////////////////////////////////////////////////////////////////
   // Address decode

   function automatic logic addr_is(input logic [7:0] a,
                                    input logic [7:0] target);
      addr_is = (a == target);
   endfunction

   pcrb_pkg::pcrb_state_t  state;
   pcrb_pkg::pcrb_state_t  next_state;
   logic                   wr_low;
   logic                   wr_high;
   logic                   wr_range;

   assign wr_low   = req.wr_en &&
                     addr_is(req.addr, pcrb_pkg::ADDR_OFFSET_LOW);
   assign wr_high  = req.wr_en &&
                     addr_is(req.addr, pcrb_pkg::ADDR_OFFSET_HIGH);
   assign wr_range = req.wr_en &&
                     addr_is(req.addr, pcrb_pkg::ADDR_PULL_RANGE);

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      next_state = state;
      next_state.update = 1'b0;
      next_state.rsp.valid = 1'b0;
      // Factory range taken once after reset release
      if (!state.range_loaded) begin
         next_state.pull_range   = factory_range;
         next_state.range_loaded = 1'b1;
      end
      if (wr_low) begin
         next_state.low_word = req.wdata[pcrb_pkg::LOW_W-1:0];
      end
      if (wr_high) begin
         next_state.high_word = req.wdata[pcrb_pkg::HIGH_W-1:0];
         // Upper bits 15..11 dropped here
         if (oe_sw_mode) begin
            next_state.oe_bit = req.wdata[pcrb_pkg::OE_BIT];
         end
         // Low and high join only on the high write
         next_state.applied = {req.wdata[pcrb_pkg::HIGH_W-1:0],
                               state.low_word};
         next_state.update  = 1'b1;
      end
      if (wr_range) begin
         // A write in the load cycle wins over the factory value
         next_state.pull_range =
            req.wdata[pcrb_pkg::RANGE_W-1:0];
      end
      if (req.rd_en) begin
         next_state.rsp.valid = 1'b1;
         next_state.rsp.data  = pcrb_pkg::READ_ZERO;
         if (addr_is(req.addr, pcrb_pkg::ADDR_OFFSET_LOW)) begin
            next_state.rsp.data = state.low_word;
         end else if (addr_is(req.addr, pcrb_pkg::ADDR_OFFSET_HIGH)) begin
            next_state.rsp.data[pcrb_pkg::HIGH_W-1:0] = state.high_word;
            next_state.rsp.data[pcrb_pkg::OE_BIT]     = state.oe_bit;
         end else if (addr_is(req.addr, pcrb_pkg::ADDR_PULL_RANGE)) begin
            next_state.rsp.data[pcrb_pkg::RANGE_W-1:0] = state.pull_range;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state.low_word     <= pcrb_pkg::LOW_RESET;
         state.high_word    <= pcrb_pkg::HIGH_RESET;
         state.oe_bit       <= pcrb_pkg::OE_RESET;
         state.pull_range   <= pcrb_pkg::RANGE_RESET;
         state.range_loaded <= 1'b0;
         state.applied      <= '0;
         state.update       <= 1'b0;
         state.rsp          <= '0;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign rsp              = state.rsp;
   assign pull_offset_word = signed'(state.applied);
   assign offset_update    = state.update;
   assign out_drive_enable = state.oe_bit && oe_sw_mode;
   assign pull_range       = state.pull_range;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   property p_high_applies;
      wr_high |=> offset_update &&
         state.applied == {$past(req.wdata[9:0]), $past(state.low_word)};
   endproperty
   a_high_applies: assert property (p_high_applies)
      else $error("high write did not apply offset");

   property p_low_holds;
      wr_low && !wr_high |=> $stable(state.applied) && !offset_update;
   endproperty
   a_low_holds: assert property (p_low_holds)
      else $error("low write changed applied offset");

   property p_update_cause;
      offset_update |-> $past(wr_high);
   endproperty
   a_update_cause: assert property (p_update_cause)
      else $error("offset update without high write");

   property p_oe_hw_ignored;
      wr_high && !oe_sw_mode |=> $stable(state.oe_bit);
   endproperty
   a_oe_hw_ignored: assert property (p_oe_hw_ignored)
      else $error("enable bit written under pin control");

   property p_oe_sw_write;
      wr_high && oe_sw_mode |=> state.oe_bit == $past(req.wdata[10]);
   endproperty
   a_oe_sw_write: assert property (p_oe_sw_write)
      else $error("enable bit not written");

   property p_high_read;
      req.rd_en && req.addr == 8'h01 |=>
         rsp.valid && rsp.data[15:11] == 5'h00 &&
         rsp.data[10:0] == {$past(state.oe_bit), $past(state.high_word)};
   endproperty
   a_high_read: assert property (p_high_read)
      else $error("high register read wrong");

   property p_low_read;
      req.rd_en && req.addr == 8'h00 |=>
         rsp.valid && rsp.data == $past(state.low_word);
   endproperty
   a_low_read: assert property (p_low_read)
      else $error("low register read wrong");

   property p_range_read;
      req.rd_en && req.addr == 8'h02 |=>
         rsp.valid && rsp.data == {12'h000, $past(state.pull_range)};
   endproperty
   a_range_read: assert property (p_range_read)
      else $error("range register read wrong");

   property p_range_strap;
      !state.range_loaded && !wr_range |=>
         state.range_loaded && pull_range == $past(factory_range);
   endproperty
   a_range_strap: assert property (p_range_strap)
      else $error("factory range not loaded");

   property p_reset_clear;
      !state.range_loaded |-> state.applied == 26'h0000000 &&
         !state.oe_bit && state.low_word == 16'h0000;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("state not clear after reset");

   ////////////////////////////////////////////////////////////////////////
   // Register field checks

   property p_low_write;
      wr_low |=> state.low_word == $past(req.wdata);
   endproperty
   a_low_write: assert property (p_low_write)
      else $error("low word not stored");

   property p_high_write;
      wr_high |=> state.high_word == $past(req.wdata[9:0]);
   endproperty
   a_high_write: assert property (p_high_write)
      else $error("high word not stored");

   property p_low_keep;
      !wr_low |=> $stable(state.low_word);
   endproperty
   a_low_keep: assert property (p_low_keep)
      else $error("low word changed without a write");

   property p_high_keep;
      !wr_high |=> $stable(state.high_word);
   endproperty
   a_high_keep: assert property (p_high_keep)
      else $error("high word changed without a write");

   property p_applied_keep;
      !wr_high |=> $stable(pull_offset_word);
   endproperty
   a_applied_keep: assert property (p_applied_keep)
      else $error("offset moved without a high write");

   property p_offset_sign;
      offset_update |->
         (pull_offset_word < 0) == state.high_word[pcrb_pkg::HIGH_W-1];
   endproperty
   a_offset_sign: assert property (p_offset_sign)
      else $error("offset sign differs from top bit");

   property p_oe_keep;
      !wr_high |=> $stable(state.oe_bit);
   endproperty
   a_oe_keep: assert property (p_oe_keep)
      else $error("enable bit changed without a write");

   property p_oe_pin_mode;
      !oe_sw_mode |-> !out_drive_enable;
   endproperty
   a_oe_pin_mode: assert property (p_oe_pin_mode)
      else $error("driver enabled under pin control");

   property p_oe_sw_follow;
      oe_sw_mode |-> out_drive_enable == state.oe_bit;
   endproperty
   a_oe_sw_follow: assert property (p_oe_sw_follow)
      else $error("driver does not follow enable bit");

   property p_range_write;
      wr_range |=> pull_range == $past(req.wdata[3:0]);
   endproperty
   a_range_write: assert property (p_range_write)
      else $error("range field not stored");

   property p_range_keep;
      state.range_loaded && !wr_range |=> $stable(pull_range);
   endproperty
   a_range_keep: assert property (p_range_keep)
      else $error("range field changed without a write");

   ////////////////////////////////////////////////////////////////////////
   // Unmapped address and read answer checks

   property p_unmapped_write;
      req.wr_en && req.addr > pcrb_pkg::ADDR_PULL_RANGE |=>
         $stable(state.low_word) && $stable(state.high_word) &&
         $stable(state.oe_bit) && !offset_update;
   endproperty
   a_unmapped_write: assert property (p_unmapped_write)
      else $error("unmapped write changed a register");

   property p_unmapped_read;
      req.rd_en && req.addr > pcrb_pkg::ADDR_PULL_RANGE |=>
         rsp.valid && rsp.data == 16'h0000;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("unmapped read not zero");

   property p_read_answer;
      rsp.valid |-> $past(req.rd_en);
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("read answer without a read");

   property p_read_hold;
      !req.rd_en |=> $stable(rsp.data) && !rsp.valid;
   endproperty
   a_read_hold: assert property (p_read_hold)
      else $error("read data changed without a read");

   ////////////////////////////////////////////////////////////////////////
   // Cover points

   c_low_then_high: cover property (wr_low ##[1:20] wr_high);
   c_neg_offset: cover property (offset_update && pull_offset_word < 0);
   c_hw_oe_write: cover property (wr_high && !oe_sw_mode);
   c_range_write: cover property (wr_range ##[1:4] req.rd_en);
   c_unmapped_read: cover property
      (req.rd_en && req.addr > pcrb_pkg::ADDR_PULL_RANGE);

endmodule

// ### tb/pcrb_master.sv
// Bus master model issuing register requests to the pull control bank
`timescale 1ns/1ps
module pcrb_master (
   input  wire logic             clk_sys,
   output pcrb_pkg::pcrb_req_t   req
);
   // Cycles of 25 ns in one period of the 38 kHz update limit
   localparam int UPDATE_GAP = 1053;
   int gap = 2000;

   initial req = '0;

   // Cycles since the last high word write was taken
   always @(posedge clk_sys) begin
      if (req.wr_en && req.addr == pcrb_pkg::ADDR_OFFSET_HIGH) begin
         gap <= 0;
      end else begin
         gap <= gap + 1;
      end
   end

   // One request per call, raised and dropped on falling edges
   task automatic access(input logic wr, input logic [7:0] a,
                         input logic [15:0] d);
      if (wr && a === pcrb_pkg::ADDR_OFFSET_HIGH) begin
         while (gap < UPDATE_GAP) @(posedge clk_sys);
      end
      @(negedge clk_sys);
      req = '{wr_en: wr, rd_en: !wr, addr: a, wdata: d};
      @(negedge clk_sys);
      // Address and data no longer hold once the strobe drops
      req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
   endtask
endmodule

// ### tb/testbench.sv
// Self-checking bench for the pull control register bank
`timescale 1ns/1ps
module testbench;
   logic                  clk_sys       = 1'b0;
   logic                  reset         = 1'b1;
   logic                  oe_sw_mode    = 1'b1;
   logic [3:0]            factory_range = 4'h9;
   pcrb_pkg::pcrb_req_t   req;
   pcrb_pkg::pcrb_rsp_t   rsp;
   logic signed [25:0]    pull_offset_word;
   logic                  offset_update;
   logic                  out_drive_enable;
   logic [3:0]            pull_range;
   int                    err_count     = 0;
   int                    num_checks    = 0;
   int                    cycles        = 0;

   always #12.5 clk_sys = ~clk_sys;

   pcrb_master master_u (.clk_sys(clk_sys), .req(req));

   pcrb_bank dut_u (
      .clk_sys(clk_sys), .reset(reset), .req(req),
      .oe_sw_mode(oe_sw_mode), .factory_range(factory_range),
      .rsp(rsp), .pull_offset_word(pull_offset_word),
      .offset_update(offset_update),
      .out_drive_enable(out_drive_enable), .pull_range(pull_range));

   task automatic chk(input string n, input logic [31:0] e, g);
      num_checks++;
      if (e !== g) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      master_u.access(1'b0, a, 16'h0000);
      chk("rsp.valid", 32'h1, {31'h0, rsp.valid});
      chk($sformatf("read %h", a), {16'h0, e}, {16'h0, rsp.data});
   endtask

   task automatic t_reset();
      rd(8'h00, 16'h0000);
      @(negedge clk_sys);
      chk("valid drop", 32'h0, {31'h0, rsp.valid});
      rd(8'h01, 16'h0000);
      rd(8'h02, 16'h0009);
      chk("pull_range", 32'h9, {28'h0, pull_range});
      chk("oe", 32'h0, {31'h0, out_drive_enable});
      chk("word zero", 32'h0, {6'h0, pull_offset_word});
   endtask

   task automatic t_offset();
      master_u.access(1'b1, 8'h00, 16'h0000);
      chk("early update", 32'h0, {31'h0, offset_update});
      master_u.access(1'b1, 8'h01, 16'hfe00);
      chk("update", 32'h1, {31'h0, offset_update});
      chk("word", 32'h2000000, {6'h0, pull_offset_word});
      chk("negative", 32'h1, {31'h0, pull_offset_word < 0});
      chk("oe on", 32'h1, {31'h0, out_drive_enable});
      @(negedge clk_sys);
      chk("update one cycle", 32'h0, {31'h0, offset_update});
      rd(8'h01, 16'h0600);
   endtask

   task automatic t_hw_mode();
      @(negedge clk_sys) oe_sw_mode = 1'b0;
      @(negedge clk_sys);
      chk("hw oe", 32'h0, {31'h0, out_drive_enable});
      master_u.access(1'b1, 8'h00, 16'h1234);
      chk("low held", 32'h2000000, {6'h0, pull_offset_word});
      master_u.access(1'b1, 8'h01, 16'h0155);
      @(negedge clk_sys) oe_sw_mode = 1'b1;
      @(negedge clk_sys);
      chk("oe kept", 32'h1, {31'h0, out_drive_enable});
      chk("word2", 32'h1551234, {6'h0, pull_offset_word});
      chk("positive", 32'h0, {31'h0, pull_offset_word < 0});
      rd(8'h00, 16'h1234);
      rd(8'h01, 16'h0555);
   endtask

   task automatic t_range();
      for (int i = 0; i < 16; i++) begin
         master_u.access(1'b1, 8'h02, {12'hfff, i[3:0]});
         chk("range", i, {28'h0, pull_range});
         rd(8'h02, {12'h000, i[3:0]});
      end
      master_u.access(1'b1, 8'h03, 16'hffff);
      rd(8'h03, 16'h0000);
      rd(8'h02, 16'h000f);
      chk("word kept", 32'h1551234, {6'h0, pull_offset_word});
   endtask

   task automatic t_mid_reset();
      @(negedge clk_sys);
      reset = 1'b1;
      factory_range = 4'h3;
      repeat (3) @(negedge clk_sys);
      reset = 1'b0;
      @(negedge clk_sys);
      chk("range strap", 32'h3, {28'h0, pull_range});
      chk("oe reset", 32'h0, {31'h0, out_drive_enable});
      chk("word reset", 32'h0, {6'h0, pull_offset_word});
      rd(8'h00, 16'h0000);
      rd(8'h01, 16'h0000);
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         final_report();
      end
   end

   initial begin
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys) reset = 1'b0;
      t_reset();
      t_offset();
      t_hw_mode();
      t_range();
      t_mid_reset();
      final_report();
   end
endmodule
